// file: design/pmn_clock_divider.sv
// divides the system clock down to the mii clock for either speed
`timescale 1ns/1ps
module pmn_clock_divider
  import pmn_pkg::*;
(
  // clock and reset
  input wire logic sysClk,
  input wire logic arst_n,
  // control
  input wire logic fastMode,
  // divided clock and its rising-edge strobe
  output logic miiClk,
  output logic riseStrobe
);

  logic [DIV_WIDTH-1:0] count;
  wire [DIV_WIDTH-1:0] halfLimit = fastMode ? DIV_WIDTH'(HALF_FAST - 1) : DIV_WIDTH'(HALF_SLOW - 1);
  wire halfDone = (count >= halfLimit);

  // free-running toggle divider; a speed change takes effect in the half period already running
  always_ff @(posedge sysClk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      miiClk <= 1'b0;
      riseStrobe <= 1'b0;
    end else begin
      count <= halfDone ? '0 : count + 1'b1;
      miiClk <= halfDone ? ~miiClk : miiClk;
      riseStrobe <= halfDone & ~miiClk;
    end
  end

endmodule

// file: design/pmn_level_sync.sv
// three-stage level synchroniser; a change counts when stages two and three agree
`timescale 1ns/1ps
module pmn_level_sync
  import pmn_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);

  // stage1 is read by stage2 only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
    end else begin
      stage1 <= async;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= (agree & stage3) | (~agree & level);
    end
  end

endmodule

// file: design/pmn_mii_phy.sv
// phy-side mii: receive framing from 5b symbols, transmit nibble encoding with halt on a tx error in fast mode only
`timescale 1ns/1ps
module pmn_mii_phy
  import pmn_pkg::*;
#(
  parameter logic [4:0] TEST_SYMBOL = 5'h00
) (
  // system clock domain
  input wire logic sysClk,
  input wire logic arst_n,
  // configuration, static levels from outside the domain
  input wire logic fastMode,
  input wire logic invalidCodeTest,
  // media receive side, on the recovered symbol clock
  input wire logic rxSymClk,
  input wire logic [4:0] rxSymbol,
  input wire logic rxSignalError,
  // mii receive toward the mac
  output logic miiRxClk,
  output logic [3:0] miiRxData,
  output logic [3:0] miiRxDataOe,
  output logic miiRxValid,
  output logic miiRxValidOe,
  output logic miiRxError,
  output logic miiRxErrorOe,
  input wire logic receive_float_request,
  // mii transmit from the mac
  output logic miiTxClk,
  input wire logic miiTxEnable,
  input wire logic miiTxError,
  input wire logic [3:0] miiTxData,
  // media transmit side, one symbol per tx clock
  output logic txSymValid,
  output logic [4:0] txSymbol
);

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_GOT_J = 5'h02,
    RX_DATA = 5'h04,
    RX_GOT_T = 5'h08,
    RX_BAD = 5'h10
  } pmn_rx_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // 4b/5b tables
  function automatic logic [3:0] decode5(input logic [4:0] sym, output logic ok);
    ok = 1'b1;
    case (sym)
      5'h1E: decode5 = 4'h0;
      5'h09: decode5 = 4'h1;
      5'h14: decode5 = 4'h2;
      5'h15: decode5 = 4'h3;
      5'h0A: decode5 = 4'h4;
      5'h0B: decode5 = 4'h5;
      5'h0E: decode5 = 4'h6;
      5'h0F: decode5 = 4'h7;
      5'h12: decode5 = 4'h8;
      5'h13: decode5 = 4'h9;
      5'h16: decode5 = 4'hA;
      5'h17: decode5 = 4'hB;
      5'h1A: decode5 = 4'hC;
      5'h1B: decode5 = 4'hD;
      5'h1C: decode5 = 4'hE;
      5'h1D: decode5 = 4'hF;
      default: begin
        decode5 = 4'h0;
        ok = 1'b0;
      end
    endcase
  endfunction

  function automatic logic [4:0] encode4(input logic [3:0] nib);
    logic [4:0] t [16];
    t = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
          5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    encode4 = t[nib];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // clock generation in the system domain
  logic divClk;
  logic divRise;
  logic fastSync;
  logic testSync;

  pmn_level_sync #(.WIDTH(2)) cfgSync (
    .clk(sysClk),
    .rst_n(arst_n),
    .async({fastMode, invalidCodeTest}),
    .level({fastSync, testSync})
  );

  pmn_clock_divider txDiv (
    .sysClk(sysClk),
    .arst_n(arst_n),
    .fastMode(fastSync),
    .miiClk(divClk),
    .riseStrobe(divRise)
  );

  // the mac sees the divided clock; tx logic runs on its rising strobe
  always_ff @(posedge sysClk or negedge arst_n) begin
    if (!arst_n) begin
      miiTxClk <= 1'b0;
    end else begin
      miiTxClk <= divClk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit path: inputs are stable at the rising edge
  wire takeTx = divRise;
  wire txErrUsed = fastSync & miiTxError;
  wire [4:0] errSymbol = testSync ? TEST_SYMBOL : SYM_HALT;
  wire [4:0] dataSymbol = encode4(miiTxData); // bit 0 is the lsb
  wire [4:0] next_txSymbol = !miiTxEnable ? SYM_IDLE : (txErrUsed ? errSymbol : dataSymbol);

  // one symbol per nibble while enabled, idle once enable drops
  always_ff @(posedge sysClk or negedge arst_n) begin
    if (!arst_n) begin
      txSymbol <= SYMBOL_RESET;
      txSymValid <= 1'b0;
    end else if (takeTx) begin
      txSymbol <= next_txSymbol;
      txSymValid <= miiTxEnable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive path, on the recovered symbol clock; the mac's rx clock output is held high, not that clock
  logic rxFast;
  logic rxFloat;

  pmn_level_sync #(.WIDTH(2)) rxCfgSync (
    .clk(rxSymClk),
    .rst_n(arst_n),
    .async({fastMode, receive_float_request}),
    .level({rxFast, rxFloat})
  );

  pmn_rx_state_type rxState;
  pmn_rx_state_type next_rxState;
  logic symOk;
  logic [3:0] symNibble;
  logic frameError;
  logic falseCarrier;

  // decode and framing decisions
  always_comb begin
    symNibble = decode5(rxSymbol, symOk);
    next_rxState = rxState;
    frameError = 1'b0;
    falseCarrier = 1'b0;
    case (rxState)
      RX_IDLE: begin
        if (rxSymbol == SYM_J) begin
          next_rxState = RX_GOT_J;
        end else if (rxSymbol != SYM_IDLE) begin
          falseCarrier = 1'b1;
          next_rxState = RX_BAD;
        end
      end
      RX_GOT_J: begin
        // valid only after the full j/k pair
        if (rxSymbol == SYM_K) begin
          next_rxState = RX_DATA;
        end else begin
          falseCarrier = 1'b1;
          next_rxState = RX_BAD;
        end
      end
      RX_DATA: begin
        if (rxSignalError) begin
          frameError = 1'b1;
          next_rxState = RX_BAD;
        end else if (rxSymbol == SYM_T) begin
          next_rxState = RX_GOT_T;
        end else if (rxSymbol == SYM_IDLE) begin
          frameError = 1'b1;
          next_rxState = RX_IDLE;
        end else if (!symOk) begin
          frameError = 1'b1;
        end
      end
      RX_GOT_T: begin
        next_rxState = RX_IDLE;
      end
      RX_BAD: begin
        // wait for line idle before hunting again
        if (rxSymbol == SYM_IDLE) begin
          next_rxState = RX_IDLE;
        end
      end
      default: begin
        next_rxState = RX_IDLE;
      end
    endcase
  end

  wire stayValid = (next_rxState == RX_DATA);
  wire next_rxValid = stayValid & ~rxSignalError;
  wire next_rxError = rxFast & (frameError | falseCarrier);
  wire [3:0] next_rxData = next_rxValid ? symNibble : NIBBLE_RESET;

  // all mii receive outputs change only on the rx clock
  always_ff @(posedge rxSymClk or negedge arst_n) begin
    if (!arst_n) begin
      rxState <= RX_IDLE;
      miiRxValid <= 1'b0;
      miiRxError <= 1'b0;
      miiRxData <= NIBBLE_RESET;
    end else begin
      rxState <= next_rxState;
      miiRxValid <= next_rxValid;
      miiRxError <= next_rxError;
      miiRxData <= next_rxData;
    end
  end

  // release the shared bus while the float request is high, so one phy drives it
  always_ff @(posedge rxSymClk or negedge arst_n) begin
    if (!arst_n) begin
      miiRxDataOe <= 4'h0;
      miiRxValidOe <= 1'b0;
      miiRxErrorOe <= 1'b0;
    end else begin
      miiRxDataOe <= {4{~rxFloat}};
      miiRxValidOe <= ~rxFloat;
      miiRxErrorOe <= ~rxFloat;
    end
  end

  // receive clock output; a flop on the falling edge that goes high after reset and stays high
  always_ff @(negedge rxSymClk or negedge arst_n) begin
    if (!arst_n) begin
      miiRxClk <= 1'b0;
    end else begin
      miiRxClk <= 1'b1;
    end
  end

endmodule

// file: design/pmn_pkg.sv
// package for the phy-side mii nibble interface: constants, codes and carriers
package pmn_pkg;

  // 4b/5b control symbols seen at the media side
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0D;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [4:0] SYM_IDLE = 5'h1F;
  localparam logic [4:0] SYM_HALT = 5'h04;

  // clock figures
  localparam int SYS_CLK_MHZ = 200;
  localparam int MII_FAST_MHZ_X10 = 250;
  localparam int MII_SLOW_MHZ_X10 = 25;
  // half periods of the generated mii clocks in system clock cycles
  localparam int HALF_FAST = (SYS_CLK_MHZ * 10) / (MII_FAST_MHZ_X10 * 2);
  localparam int HALF_SLOW = (SYS_CLK_MHZ * 10) / (MII_SLOW_MHZ_X10 * 2);
  localparam int DIV_WIDTH = 6;
  localparam int SYNC_STAGES = 3;

  // reset values
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [4:0] SYMBOL_RESET = 5'h1F;

  // receive nibble as presented to the mac
  typedef struct packed {
    logic valid;
    logic error;
    logic [3:0] data;
  } pmn_rx_nibble_type;

  // transmit nibble as taken from the mac
  typedef struct packed {
    logic enable;
    logic error;
    logic [3:0] data;
  } pmn_tx_nibble_type;

  // symbol on the media side
  typedef struct packed {
    logic valid;
    logic [4:0] code;
  } pmn_symbol_type;

endpackage

// file: testbench/pmn_mac_model.sv
// mac-side model: drives transmit nibbles in step with the phy's transmit clock
`timescale 1ns/1ps
module pmn_mac_model
  import pmn_pkg::*;
(
  // clock from the phy
  input wire logic miiTxClk,
  // nibble toward the phy
  output pmn_tx_nibble_type tx
);
  pmn_tx_nibble_type plan[$];
  pmn_tx_nibble_type sent[$];
  initial tx = '0;
  //////////////////////////////////////////////////
  // change just after the fall so the phy sees a settled nibble at the rise; idle data toggles
  always @(negedge miiTxClk) begin
    #1;
    tx = plan.size() ? plan.pop_front() : {2'b00, ~tx.data};
    sent.push_back(tx);
  end
endmodule

// file: testbench/pmn_mii_phy_sva.sv
// checker for the phy-side mii nibble interface
`timescale 1ns/1ps
module pmn_mii_phy_sva
  import pmn_pkg::*;
(
  // clocks and reset
  input wire logic sysClk,
  input wire logic arst_n,
  input wire logic rxSymClk,
  // receive side
  input wire logic fastMode,
  input wire logic [4:0] rxSymbol,
  input wire logic rxSignalError,
  input wire logic receive_float_request,
  input wire logic [3:0] miiRxData,
  input wire logic [3:0] miiRxDataOe,
  input wire logic miiRxValid,
  input wire logic miiRxError,
  input wire logic miiRxErrorOe,
  // transmit side
  input wire logic miiTxClk,
  input wire logic txSymValid,
  input wire logic [4:0] txSymbol
);
  logic [5:0] fastAge;
  wire logic [5:0] next_fastAge = fastMode ? fastAge + 6'(fastAge != 6'h3F) : 6'h00;
  // the divider may run one odd period after a mode change, so wait for a steady fast mode
  always_ff @(posedge sysClk or negedge arst_n) begin
    if (!arst_n) fastAge <= 6'h00;
    else fastAge <= next_fastAge;
  end
  //////////////////////////////////////////////////
  a_valid_after_jk: assert property (@(posedge rxSymClk) disable iff (!arst_n)
    $rose(miiRxValid) |-> $past(rxSymbol, 2) == SYM_J && $past(rxSymbol) == SYM_K) else $error("valid without j k");
  a_valid_drop_end: assert property (@(posedge rxSymClk) disable iff (!arst_n)
    miiRxValid && (rxSymbol == SYM_T || rxSignalError) |=> !miiRxValid) else $error("valid held past end");
  a_idle_data_zero: assert property (@(posedge rxSymClk) disable iff (!arst_n)
    !miiRxValid |-> miiRxData == 4'h0) else $error("data outside frame");
  a_slow_no_error: assert property (@(posedge rxSymClk) disable iff (!arst_n)
    (!fastMode)[*6] |-> !miiRxError) else $error("receive error at slow speed");
  a_float_release: assert property (@(posedge rxSymClk) disable iff (!arst_n)
    receive_float_request[*6] |-> miiRxDataOe == 4'h0 && !miiRxErrorOe) else $error("driving while floated");
  a_tx_clk_step: assert property (@(posedge sysClk) disable iff (!arst_n)
    $changed(txSymbol) |-> miiTxClk || $past(miiTxClk)) else $error("symbol off tx clock");
  a_tx_idle_sym: assert property (@(posedge sysClk) disable iff (!arst_n)
    !txSymValid |-> txSymbol == SYM_IDLE) else $error("symbol while not sending");
  a_fast_period: assert property (@(posedge sysClk) disable iff (!arst_n)
    $rose(miiTxClk) && fastAge == 6'h3F |-> ##4 $fell(miiTxClk) ##4 $rose(miiTxClk)) else $error("tx clock period");
  c_frame: cover property (@(posedge rxSymClk) $rose(miiRxValid));
  c_rx_error: cover property (@(posedge rxSymClk) miiRxError);
  c_halt: cover property (@(posedge sysClk) txSymValid && txSymbol == SYM_HALT);
endmodule

// file: testbench/tb_phy_mii_nibble_interface.sv
// self-checking bench for the phy-side mii nibble interface
`timescale 1ns/1ps
module tb_phy_mii_nibble_interface;
  import pmn_pkg::*;
  localparam logic [4:0] TSYM = 5'h19;
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic sysClk = 0, rxSymClk = 0, arst_n = 0, fastMode = 1, codeTest = 0, floatReq = 0, rxErr = 0;
  logic [4:0] rxSymbol = SYM_IDLE;
  logic miiRxClk, miiRxValid, miiRxValidOe, miiRxError, miiRxErrorOe, miiTxClk, txSymValid;
  logic [3:0] miiRxData, miiRxDataOe;
  logic [4:0] txSymbol;
  pmn_tx_nibble_type txn, txPop;
  pmn_rx_nibble_type rxExp[$];
  int bad_count = 0, samples_checked = 0;
  realtime t0;
  // link clock runs on idles, out of phase with the system clock
  initial forever #2.5 sysClk = ~sysClk;
  initial begin
    #3;
    forever #6 rxSymClk = ~rxSymClk;
  end
  pmn_mii_phy #(.TEST_SYMBOL(TSYM)) u_dut (.sysClk(sysClk), .arst_n(arst_n), .fastMode(fastMode),
    .invalidCodeTest(codeTest), .rxSymClk(rxSymClk), .rxSymbol(rxSymbol), .rxSignalError(rxErr),
    .miiRxClk(miiRxClk), .miiRxData(miiRxData), .miiRxDataOe(miiRxDataOe), .miiRxValid(miiRxValid),
    .miiRxValidOe(miiRxValidOe), .miiRxError(miiRxError), .miiRxErrorOe(miiRxErrorOe),
    .receive_float_request(floatReq), .miiTxClk(miiTxClk), .miiTxEnable(txn.enable),
    .miiTxError(txn.error), .miiTxData(txn.data), .txSymValid(txSymValid), .txSymbol(txSymbol));
  pmn_mac_model u_mac (.miiTxClk(miiTxClk), .tx(txn));
  //////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one symbol per falling link edge, noting what the mac should see after the next rising edge
  task automatic rxs(input logic [4:0] s, input logic e, input logic v, input logic er, input logic [3:0] d);
    @(negedge rxSymClk);
    rxSymbol = s;
    rxErr = e;
    rxExp.push_back({v, er & fastMode, d});
  endtask
  task automatic frame(input int n, input bit cut);
    logic [3:0] d;
    rxs(SYM_J, 0, 0, 0, 4'h0);
    rxs(SYM_K, 0, 1, 0, 4'h0);
    repeat (n) begin
      d = 4'($urandom);
      rxs(ENC[d], 0, 1, 0, d);
    end
    if (cut) rxs(ENC[3], 1, 0, 1, 4'h0);
    else begin
      rxs(SYM_T, 0, 0, 0, 4'h0);
      rxs(SYM_R, 0, 0, 0, 4'h0);
    end
    // after a signal error the receiver waits for idle, so a stray symbol raises no new error
    rxs(ENC[5], 0, 0, !cut, 4'h0);
    rxs(SYM_IDLE, 0, 0, 0, 4'h0);
  endtask
  task automatic sendTx(input int n);
    repeat (n) u_mac.plan.push_back({1'b1, 1'($urandom), 4'($urandom)});
    wait (u_mac.plan.size() == 0);
    repeat (3) @(posedge miiTxClk);
  endtask
  task automatic per(input int p);
    repeat (2) @(posedge miiTxClk);
    t0 = $realtime;
    @(posedge miiTxClk);
    chk(32'($rtoi($realtime - t0)), p);
  endtask
  // compare results against the oldest note as they appear
  always @(posedge rxSymClk) begin
    #1;
    if (rxExp.size()) chk({miiRxValid, miiRxError, miiRxData}, rxExp.pop_front());
  end
  always @(posedge miiTxClk) begin
    #15;
    if (u_mac.sent.size()) begin
      txPop = u_mac.sent.pop_front();
      chk({txSymValid, txSymbol}, {txPop.enable, !txPop.enable ? SYM_IDLE : txPop.error && fastMode ?
        (codeTest ? TSYM : SYM_HALT) : ENC[txPop.data]});
    end
  end
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  initial begin
    void'($urandom(98381));
    repeat (12) @(posedge sysClk);
    @(negedge sysClk) arst_n = 1;
    repeat (6) @(posedge rxSymClk);
    per(40);
    sendTx(8);
    frame(4, 0);
    frame(2, 1);
    @(negedge sysClk) codeTest = 1;
    sendTx(6);
    @(negedge rxSymClk) floatReq = 1;
    repeat (6) @(negedge rxSymClk);
    chk({miiRxClk, miiRxDataOe, miiRxErrorOe, miiRxValidOe}, 7'h40);
    floatReq = 0;
    repeat (6) @(negedge rxSymClk);
    chk({miiRxClk, miiRxDataOe, miiRxErrorOe, miiRxValidOe}, 7'h7F);
    @(negedge sysClk) fastMode = 0;
    repeat (40) @(negedge sysClk);
    per(400);
    sendTx(6);
    frame(3, 1);
    close_out();
  end
endmodule
bind pmn_mii_phy pmn_mii_phy_sva u_sva (.sysClk(sysClk), .arst_n(arst_n), .rxSymClk(rxSymClk),
  .fastMode(fastMode), .rxSymbol(rxSymbol), .rxSignalError(rxSignalError),
  .receive_float_request(receive_float_request), .miiRxData(miiRxData), .miiRxDataOe(miiRxDataOe),
  .miiRxValid(miiRxValid), .miiRxError(miiRxError), .miiRxErrorOe(miiRxErrorOe),
  .miiTxClk(miiTxClk), .txSymValid(txSymValid), .txSymbol(txSymbol));
